/* File: core/tift_defs.vh */
// Purpose: Shared constants for the input frame timing front end.
// Assumes: Core clock of 40 MHz; times are in nanoseconds.
// Notes:   Cycle counts are derived from the times where they are used; only the frame tolerance is given in cycles.
`ifndef TIFT_DEFS_VH
`define TIFT_DEFS_VH

`define TIFT_CLK_MHZ        40
`define TIFT_FRAME_NS       125000
`define TIFT_FP_NARROW_NS   61
`define TIFT_FP_MID_NS      122
`define TIFT_FP_WIDE_NS     244
`define TIFT_FP_LIMIT_NS    488
`define TIFT_NS_PER_US      1000
`define TIFT_SETTLE_DONE    2'h3
`define TIFT_FRAME_TOL_CYC  16
`define TIFT_CNT_W          14
`define TIFT_EDGE_W         11
`define TIFT_BITS_PER_CHAN  4
`define TIFT_WIDTH_NARROW   2'h0
`define TIFT_WIDTH_MID      2'h1
`define TIFT_WIDTH_WIDE     2'h2
`define TIFT_WIDTH_BAD      2'h3

`endif

/* File: core/tift_input_frame_timing.v */
// Purpose: Finds the input frame boundary from a serial bit clock and frame pulse.
// Assumes: Serial clock and frame pulse are asynchronous pins sampled by clk_in.
// Notes:   The serial clock must be slow enough that 40 MHz sampling sees each phase.
//
// Contract
// [R1] Accept a 4.096, 8.192 or 16.384 MHz bit clock for input timing.
// [R2] Source clock runs at least twice the highest input data rate.
// [R3] Default: clock falling edge during the frame pulse starts each frame.
// [R4] With edge select set, the rising clock edge marks the boundary.
// [R5] Recognise frame pulses about 61, 122 or 244 ns wide.
// [R6] Source drives the pulse width matching the fastest active stream.
// [R7] Exactly one frame pulse per 8 kHz frame period is expected.
// [R8] With polarity select high, an active-high frame pulse is accepted.
// [R9] Bit and channel counters restart at every detected frame boundary.
`timescale 1ns/10ps
`default_nettype none
`include "tift_defs.vh"

module tift_input_frame_timing #(
    parameter integer FRAME_CYCLES = `TIFT_FRAME_NS * `TIFT_CLK_MHZ / 1000,
    parameter integer FRAME_TOL    = `TIFT_FRAME_TOL_CYC
) (
    // Clock and reset
    input  wire                     clk_in,
    input  wire                     reset_n_in,
    // Timing source pins
    input  wire                     serial_clock_in,
    input  wire                     frame_pulse_in,
    // Static configuration
    input  wire                     clock_edge_sel_in,
    input  wire                     frame_pulse_polarity_sel_in,
    // Timing outputs
    output reg                      frame_start_out,
    output reg                      bit_edge_out,
    output reg  [`TIFT_EDGE_W-1:0]  bit_count_out,
    output reg  [`TIFT_EDGE_W-`TIFT_BITS_PER_CHAN-1:0] channel_count_out,
    output reg  [1:0]               pulse_width_out,
    output reg                      frame_lock_out,
    output reg                      frame_error_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Width classes in core cycles, split halfway between neighbouring widths.
    localparam integer NARROW_MID_CYC = (`TIFT_FP_NARROW_NS + `TIFT_FP_MID_NS) * `TIFT_CLK_MHZ
                                        / (2 * `TIFT_NS_PER_US);
    localparam integer MID_WIDE_CYC   = (`TIFT_FP_MID_NS + `TIFT_FP_WIDE_NS) * `TIFT_CLK_MHZ
                                        / (2 * `TIFT_NS_PER_US);
    localparam integer WIDE_MAX_CYC   = `TIFT_FP_LIMIT_NS * `TIFT_CLK_MHZ / `TIFT_NS_PER_US;
    localparam integer PER_MIN_INT    = FRAME_CYCLES - FRAME_TOL;
    localparam integer PER_MAX_INT    = FRAME_CYCLES + FRAME_TOL;
    localparam [`TIFT_CNT_W-1:0]  PER_MIN    = PER_MIN_INT[`TIFT_CNT_W-1:0];
    localparam [`TIFT_CNT_W-1:0]  PER_MAX    = PER_MAX_INT[`TIFT_CNT_W-1:0];
    localparam [`TIFT_CNT_W-1:0]  CNT_ZERO   = {`TIFT_CNT_W{1'b0}};
    localparam [`TIFT_CNT_W-1:0]  CNT_ONE    = {{(`TIFT_CNT_W-1){1'b0}}, 1'b1};
    localparam [`TIFT_CNT_W-1:0]  CNT_ALL    = {`TIFT_CNT_W{1'b1}};
    localparam [`TIFT_EDGE_W-1:0] EDGE_ZERO  = {`TIFT_EDGE_W{1'b0}};
    localparam [`TIFT_EDGE_W-1:0] EDGE_ONE   = {{(`TIFT_EDGE_W-1){1'b0}}, 1'b1};
    localparam [1:0]              SETTLE_ONE = 2'h1;

    // Maps a measured active time in core cycles onto one of the three data rates, or TIFT_WIDTH_BAD past the limit.
    function [1:0] classify_width;
        input [`TIFT_CNT_W-1:0] cycles;
        begin
            if (cycles <= NARROW_MID_CYC[`TIFT_CNT_W-1:0]) begin
                classify_width = `TIFT_WIDTH_NARROW;
            end else if (cycles <= MID_WIDE_CYC[`TIFT_CNT_W-1:0]) begin
                classify_width = `TIFT_WIDTH_MID;
            end else if (cycles <= WIDE_MAX_CYC[`TIFT_CNT_W-1:0]) begin
                classify_width = `TIFT_WIDTH_WIDE;
            end else begin
                classify_width = `TIFT_WIDTH_BAD;
            end
        end
    endfunction

    // Saturating increment, so a stuck pin cannot wrap a measurement back into range.
    function [`TIFT_CNT_W-1:0] sat_inc;
        input [`TIFT_CNT_W-1:0] value;
        begin
            if (value == CNT_ALL) begin
                sat_inc = value;
            end else begin
                sat_inc = value + CNT_ONE;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    reg  [1:0]              ck_sync_reg;
    reg  [1:0]              fp_sync_reg;
    reg  [1:0]              settle_reg;
    reg                     ck_prev_reg;
    reg                     fp_act_prev_reg;
    reg                     armed_reg;
    reg                     armed_next;
    reg  [`TIFT_CNT_W-1:0]  period_reg;
    reg  [`TIFT_CNT_W-1:0]  period_next;
    reg  [`TIFT_CNT_W-1:0]  width_reg;
    reg  [`TIFT_CNT_W-1:0]  width_next;
    reg  [`TIFT_EDGE_W-1:0] edge_cnt_reg;
    reg  [`TIFT_EDGE_W-1:0] edge_cnt_next;
    reg  [1:0]              pulse_width_next;
    reg                     frame_lock_next;
    reg                     frame_error_next;

    // Nothing is judged until the synchronisers and the edge history hold real pin
    // samples; otherwise the reset value of the history would look like an edge.
    wire settled  = (settle_reg == `TIFT_SETTLE_DONE);
    wire ck_now   = ck_sync_reg[1];
    wire fp_act   = settled & (frame_pulse_polarity_sel_in ? fp_sync_reg[1] : ~fp_sync_reg[1]);  // [R8]
    wire rise     = settled & ck_now & ~ck_prev_reg;
    wire fall     = settled & ~ck_now & ck_prev_reg;
    wire sel_edge = clock_edge_sel_in ? rise : fall;  // [R3] [R4]
    // Armed keeps a wide pulse, which spans several clock edges, to one boundary.
    wire boundary = sel_edge & fp_act & armed_reg;  // [R3]

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge history.
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            ck_sync_reg     <= 2'h0;
            fp_sync_reg     <= 2'h0;
            settle_reg      <= 2'h0;
            ck_prev_reg     <= 1'b0;
            fp_act_prev_reg <= 1'b0;
        end else begin
            ck_sync_reg     <= {ck_sync_reg[0], serial_clock_in};
            fp_sync_reg     <= {fp_sync_reg[0], frame_pulse_in};
            ck_prev_reg     <= ck_now;
            fp_act_prev_reg <= fp_act;
            if (!settled) begin
                settle_reg <= settle_reg + SETTLE_ONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always @* begin
        armed_next = armed_reg;
        if (boundary) begin
            armed_next = 1'b0;
        end else if (settled && !fp_act) begin
            armed_next = 1'b1;
        end
    end

    // Pulse width is measured on the active level and judged when it ends.
    always @* begin
        width_next       = width_reg;
        pulse_width_next = pulse_width_out;
        if (fp_act) begin
            width_next = sat_inc(width_reg);
        end else begin
            width_next = CNT_ZERO;
            if (fp_act_prev_reg) begin
                pulse_width_next = classify_width(width_reg);  // [R5]
            end
        end
    end

    // Counting assumes two serial clocks per data bit.
    always @* begin
        edge_cnt_next = edge_cnt_reg;
        if (boundary) begin
            edge_cnt_next = EDGE_ZERO;  // [R9]
        end else if (sel_edge) begin
            edge_cnt_next = edge_cnt_reg + EDGE_ONE;  // [R1]
        end
    end

    // One pulse per 8 kHz frame: early or missing pulses are flagged.
    always @* begin
        period_next      = sat_inc(period_reg);
        frame_lock_next  = frame_lock_out;
        frame_error_next = 1'b0;
        if (boundary) begin
            period_next     = CNT_ZERO;
            frame_lock_next = 1'b1;
            if (frame_lock_out && (period_reg < PER_MIN || period_reg > PER_MAX)) begin
                frame_error_next = 1'b1;  // [R7]
            end
        end else if (frame_lock_out && period_reg == PER_MAX) begin
            frame_error_next = 1'b1;  // [R7]
            frame_lock_next  = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            armed_reg         <= 1'b0;
            period_reg        <= CNT_ZERO;
            width_reg         <= CNT_ZERO;
            edge_cnt_reg      <= EDGE_ZERO;
            frame_start_out   <= 1'b0;
            bit_edge_out      <= 1'b0;
            bit_count_out     <= EDGE_ZERO;
            channel_count_out <= {(`TIFT_EDGE_W-`TIFT_BITS_PER_CHAN){1'b0}};
            pulse_width_out   <= `TIFT_WIDTH_NARROW;
            frame_lock_out    <= 1'b0;
            frame_error_out   <= 1'b0;
        end else begin
            armed_reg         <= armed_next;
            period_reg        <= period_next;
            width_reg         <= width_next;
            edge_cnt_reg      <= edge_cnt_next;
            frame_start_out   <= boundary;
            bit_edge_out      <= sel_edge;  // [R1]
            bit_count_out     <= edge_cnt_reg;
            channel_count_out <= edge_cnt_reg[`TIFT_EDGE_W-1:`TIFT_BITS_PER_CHAN];
            pulse_width_out   <= pulse_width_next;  // [R5]
            frame_lock_out    <= frame_lock_next;
            frame_error_out   <= frame_error_next;
        end
    end

endmodule
`default_nettype wire

/* File: test/tift_chk.sv */
// Purpose: Port assertions for the input frame timing block.
// Assumes: Pins pass a two-stage synchroniser; outputs are registered.
// Notes:   Pin samples are checked exactly three and four cycles back, with no slack.
`timescale 1ns/10ps
`default_nettype none
module tift_chk #(parameter integer FRAME_CYCLES = 5000, parameter integer FRAME_TOL = 16) (
    // Pins, clock and configuration
    input wire logic        clk_in,
    input wire logic        reset_n_in,
    input wire logic        serial_clock_in,
    input wire logic        frame_pulse_in,
    input wire logic        clock_edge_sel_in,
    input wire logic        frame_pulse_polarity_sel_in,
    // Timing outputs
    input wire logic        frame_start_out,
    input wire logic        bit_edge_out,
    input wire logic        frame_error_out,
    input wire logic [10:0] bit_count_out,
    input wire logic [6:0]  channel_count_out
);
    logic [13:0] gap_reg;
    always @(posedge clk_in) gap_reg <= (!reset_n_in || frame_start_out) ? 14'h0 : gap_reg + 14'h1;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    start_clear_a: assert property (frame_start_out |=> bit_count_out == 11'h0) else $error("no clear");
    chan_map_a: assert property (channel_count_out == bit_count_out[10:4]) else $error("channel");
    bit_step_a: assert property (
        bit_edge_out && !frame_start_out |=> bit_count_out == $past(bit_count_out) + 11'h1) else $error("step");
    fall_edge_a: assert property (
        frame_start_out && !clock_edge_sel_in |-> !$past(serial_clock_in, 3) && $past(serial_clock_in, 4))
        else $error("fall");
    rise_edge_a: assert property (
        frame_start_out && clock_edge_sel_in |-> $past(serial_clock_in, 3) && !$past(serial_clock_in, 4))
        else $error("rise");
    pulse_act_a: assert property (
        frame_start_out |-> $past(frame_pulse_in, 3) == frame_pulse_polarity_sel_in) else $error("polarity");
    err_gap_a: assert property (frame_error_out |-> gap_reg < FRAME_CYCLES - FRAME_TOL + 3
        || gap_reg > FRAME_CYCLES + FRAME_TOL - 3) else $error("period");
endmodule
bind tift_input_frame_timing tift_chk #(.FRAME_CYCLES(FRAME_CYCLES), .FRAME_TOL(FRAME_TOL)) i_chk (.clk_in,
    .reset_n_in, .serial_clock_in, .frame_pulse_in, .clock_edge_sel_in, .frame_pulse_polarity_sel_in,
    .frame_start_out, .bit_edge_out, .frame_error_out, .bit_count_out, .channel_count_out);
`default_nettype wire

/* File: test/tift_src_model.sv */
// Purpose: Timing source model: free bit clock and one frame pulse per request.
// Assumes: Bit clock period 200 ns.
// Notes:   The pulse is centred on the selected clock edge.
`timescale 1ns/10ps
`default_nettype none
module tift_src_model (
    input  wire logic       go_in,
    input  wire logic       rise_in,
    input  wire logic       pol_in,
    input  wire logic [8:0] width_ns_in,
    output var  logic       serial_clock_out,
    output wire logic       frame_pulse_out
);
    logic act = 1'b0;
    initial begin
        serial_clock_out = 1'b1;
        forever #100 serial_clock_out = !serial_clock_out;
    end
    assign frame_pulse_out = act ? pol_in : !pol_in;
    always @(posedge go_in) begin
        // Start from the selected edge so even the widest pulse can open before the next one.
        if (rise_in) @(posedge serial_clock_out); else @(negedge serial_clock_out);
        #(200 - int'(width_ns_in) / 2) act = 1'b1;
        #(int'(width_ns_in)) act = 1'b0;
    end
endmodule
`default_nettype wire

/* File: test/tift_input_frame_timing_bench.sv */
// Purpose: Self-checking bench for the input frame timing block.
// Assumes: Frame shortened to 200 cycles, tolerance 4.
// Notes:   Configuration changes away from clock edges; it is not synchronised.
`timescale 1ns/10ps
`default_nettype none
module tift_input_frame_timing_bench;
    logic        clk_in = 1'b0, reset_n_in = 1'b0, edge_sel = 1'b0, pol_sel = 1'b0, go = 1'b0;
    logic [8:0]  width = 9'h07A;
    logic        sck, fp, start, lock, err;
    logic [10:0] bits;
    logic [1:0]  pw;
    int          err_count = 0, comparisons = 0, i;
    tift_src_model i_src (.go_in(go), .rise_in(edge_sel), .pol_in(pol_sel), .width_ns_in(width),
        .serial_clock_out(sck), .frame_pulse_out(fp));
    tift_input_frame_timing #(.FRAME_CYCLES(200), .FRAME_TOL(4)) i_dut (.clk_in, .reset_n_in,
        .serial_clock_in(sck), .frame_pulse_in(fp), .clock_edge_sel_in(edge_sel),
        .frame_pulse_polarity_sel_in(pol_sel), .frame_start_out(start), .bit_edge_out(),
        .bit_count_out(bits), .channel_count_out(), .pulse_width_out(pw), .frame_lock_out(lock),
        .frame_error_out(err));
    task automatic check(input logic [10:0] got, input logic [10:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic setup(input logic r, input logic p, input logic [8:0] w);
        @(posedge sck);
        repeat (4) @(posedge clk_in);
        edge_sel <= r;
        pol_sel <= p;
        width <= w;
        repeat (4) @(posedge clk_in);
    endtask
    task automatic frame(input logic r, input logic p, input logic [8:0] w, input logic [1:0] ew);
        setup(r, p, w);
        go <= 1'b1;
        @(posedge clk_in);
        go <= 1'b0;
        for (i = 0; i < 40 && start !== 1'b1; i++) @(negedge clk_in);
        if (i == 40) begin err_count++; finish_test; end
        @(negedge clk_in);
        check(bits, 11'h0);
        repeat (10) @(negedge clk_in);
        check({9'h0, pw}, {9'h0, ew});
    endtask
    task automatic test_edges;
        frame(1'b0, 1'b0, 9'h03D, 2'h0);
        frame(1'b0, 1'b0, 9'h0F4, 2'h2);
        frame(1'b1, 1'b0, 9'h07A, 2'h1);
        frame(1'b1, 1'b1, 9'h03D, 2'h0);
        $display("test_edges done");
    endtask
    task automatic test_period;
        setup(1'b0, 1'b0, 9'h07A);
        for (i = 0; i < 4; i++) begin
            go <= 1'b1;
            @(posedge clk_in);
            go <= 1'b0;
            repeat (199) @(posedge clk_in);
        end
        @(negedge clk_in);
        check({10'h0, lock}, 11'h1);
        for (i = 0; i < 60 && err !== 1'b1; i++) @(negedge clk_in);
        check({10'h0, err}, 11'h1);
        @(negedge clk_in);
        check({10'h0, lock}, 11'h0);
        $display("test_period done");
    endtask
    initial forever #12.5 clk_in = !clk_in;
    initial begin
        repeat (3) @(posedge clk_in);
        reset_n_in <= 1'b1;
        test_edges;
        test_period;
        finish_test;
    end
endmodule
`default_nettype wire
